// file: rtl/pe_responder.sv
// executive command interpreter: takes command words, hands the work
// to the executor port and answers with a two-word header plus data.
// assumes the executor raises op_done once per op_start and, for a
// code read, supplies program words on rd_valid after op_done.
// Behaviour
// - result codes: 1 pass, 2 fail, 3 unknown
// - failure returns fail code and reason byte
// - unknown command gets unknown reply, no execution
// - response is two header words plus data
// - result code is 4-bit field, word one
// - second 4-bit field echoes command code
// - one command at a time, every one answered
// - byte carries query data or error code
// - queries answer pass code unless length is wrong or executor fails
// - blank check: f0 blank, 0f not blank
// - version: major upper nibble, revision lower
// - successful non-query: error byte is zero
// - row or ID program verify failure reports error 1
// - any other error reports error 2
// - length field counts words including header
// - all but code read answer two words
// - read length: three per pair plus two
// - bit 15 clears at erase end, polled
`timescale 1ns/10ps
module pe_responder (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [15:0] cmd_word,
  output logic             rsp_valid,
  input  wire logic        rsp_ready,
  output logic [15:0]      rsp_word,
  output logic             arg_valid,
  output logic [15:0]      arg_word,
  output logic [11:0]      arg_index,
  output logic             op_start,
  output logic [3:0]       op_code,
  input  wire logic        op_done,
  input  wire logic        op_verify_fail,
  input  wire logic        op_error,
  input  wire logic        op_blank,
  input  wire logic [3:0]  ver_major,
  input  wire logic [3:0]  ver_minor,
  input  wire logic        rd_valid,
  output logic             rd_ready,
  input  wire logic [23:0] rd_word,
  input  wire logic        nvm_we,
  input  wire logic [15:0] nvm_wdata,
  input  wire logic        page_we,
  input  wire logic [7:0]  page_wdata,
  input  wire logic        tbl_write,
  output logic [15:0]      nvm_ctl,
  output logic [7:0]       table_page,
  output logic             erase_busy,
  output logic             erase_done,
  output logic             busy
);
  import pe_resp_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_ARGS, S_EXEC, S_WAIT, S_HDR0, S_HDR1, S_DATA
  } state_t;

  state_t      state_r;
  logic [3:0]  op_r;
  logic [11:0] len_r;
  logic [11:0] cnt_r;
  logic [15:0] n_r;
  logic [15:0] hdr_r;
  logic [15:0] size_r;
  logic [15:0] rem_r;
  logic [15:0] left_r;
  logic        data_ok_r;
  logic        cmd_take;
  logic        rsp_take;
  logic        rd_take;
  logic        pk_valid;
  logic [15:0] pk_word;
  logic        pk_in_ready;
  logic        known;
  logic        len_ok;

  // the programmer is held off until the answer has gone out
  assign cmd_ready = (state_r == S_IDLE) || (state_r == S_ARGS);
  assign cmd_take  = cmd_valid && cmd_ready;
  assign rsp_take  = rsp_valid && rsp_ready;
  assign rd_take   = rd_valid && rd_ready;
  assign known     = exp_len(op_r) != 12'h000;
  assign len_ok    = len_r == exp_len(op_r);
  assign op_code   = op_r;
  assign busy      = state_r != S_IDLE;

  assign rsp_valid = (state_r == S_HDR0) || (state_r == S_HDR1) ||
                     (state_r == S_DATA && pk_valid);
  always_comb begin
    case (state_r)
      S_HDR0:  rsp_word = hdr_r;
      S_HDR1:  rsp_word = size_r;
      default: rsp_word = pk_word;
    endcase
  end
  assign rd_ready = (state_r == S_DATA) && rem_r != 16'h0000 && pk_in_ready;

  always_ff @(posedge clk) begin
    if (rst) state_r <= S_IDLE;
    else begin
      case (state_r)
        S_IDLE:
          if (cmd_take)
            state_r <= (cmd_word[11:0] > 12'h001) ? S_ARGS : S_EXEC;
        S_ARGS:
          if (cmd_take && cnt_r + 12'h001 == len_r) state_r <= S_EXEC;
        S_EXEC:
          // unknown commands go straight to the answer
          state_r <= (known && len_ok && op_r != OP_VER_Q) ?
                     S_WAIT : S_HDR0;
        S_WAIT:
          if (op_done) state_r <= S_HDR0;
        S_HDR0:
          if (rsp_take) state_r <= S_HDR1;
        S_HDR1:
          if (rsp_take) state_r <= data_ok_r ? S_DATA : S_IDLE;
        S_DATA:
          if (rsp_take && left_r == 16'h0001) state_r <= S_IDLE;
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // command capture; the word count for a code read is the first argument
  always_ff @(posedge clk) begin
    if (rst) begin
      op_r  <= 4'h0;
      len_r <= 12'h000;
      cnt_r <= 12'h000;
      n_r   <= 16'h0000;
    end else if (cmd_take && state_r == S_IDLE) begin
      op_r  <= cmd_word[15:12];
      len_r <= cmd_word[11:0];
      cnt_r <= 12'h001;
    end else if (cmd_take) begin
      cnt_r <= cnt_r + 12'h001;
      if (op_r == OP_CODE_READ && cnt_r == 12'h001) n_r <= cmd_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arg_valid <= 1'b0;
      arg_word  <= 16'h0000;
      arg_index <= 12'h000;
    end else begin
      arg_valid <= cmd_take && state_r == S_ARGS;
      if (cmd_take) begin
        arg_word  <= cmd_word;
        arg_index <= cnt_r;
      end
    end
  end

  // header build: {result, echoed command, query/error byte}
  always_ff @(posedge clk) begin
    if (rst) begin
      hdr_r     <= 16'h0000;
      size_r    <= HDR_WORDS;
      data_ok_r <= 1'b0;
      op_start  <= 1'b0;
    end else begin
      op_start <= 1'b0;
      if (state_r == S_EXEC) begin
        size_r    <= HDR_WORDS;
        data_ok_r <= 1'b0;
        if (!known)
          hdr_r <= {RES_UNKNOWN, op_r, QE_OK};
        else if (!len_ok)
          hdr_r <= {RES_FAIL, op_r, QE_OTHER};
        else if (op_r == OP_VER_Q)
          hdr_r <= {RES_PASS, op_r, ver_major, ver_minor};
        else
          op_start <= 1'b1;
      end else if (state_r == S_WAIT && op_done) begin
        if (op_error)
          hdr_r <= {RES_FAIL, op_r, QE_OTHER};
        else if (op_verify_fail)
          hdr_r <= {RES_FAIL, op_r,
                    (op_r == OP_ROW_PROG || op_r == OP_ID_PROG) ?
                    QE_VERIFY : QE_OTHER};
        else if (op_r == OP_BLANK_Q)
          hdr_r <= {RES_PASS, op_r,
                    op_blank ? QE_BLANK : QE_NOT_BLANK};
        else begin
          hdr_r <= {RES_PASS, op_r, QE_OK};
          if (op_r == OP_CODE_READ) begin
            size_r    <= rsp_len(n_r);
            data_ok_r <= n_r != 16'h0000;
          end
        end
      end
    end
  end

  // counts of program words still to fetch and data words still to send
  always_ff @(posedge clk) begin
    if (rst) begin
      rem_r  <= 16'h0000;
      left_r <= 16'h0000;
    end else if (state_r == S_HDR0) begin
      rem_r  <= n_r;
      left_r <= size_r - HDR_WORDS;
    end else begin
      if (rd_take) rem_r <= rem_r - 16'h0001;
      if (state_r == S_DATA && rsp_take) left_r <= left_r - 16'h0001;
    end
  end

  resp_packer u_packer (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rd_take),
    .in_ready  (pk_in_ready),
    .in_word   (rd_word),
    .in_last   (rem_r == 16'h0001),
    .out_valid (pk_valid),
    .out_ready (rsp_ready && state_r == S_DATA),
    .out_word  (pk_word)
  );

  // the programmer runs the erase sequence through these ports
  nvm_erase_ctrl u_nvm (
    .clk        (clk),
    .rst        (rst),
    .ctl_we     (nvm_we),
    .ctl_wdata  (nvm_wdata),
    .page_we    (page_we),
    .page_wdata (page_wdata),
    .tbl_write  (tbl_write),
    .ctl_q      (nvm_ctl),
    .page_q     (table_page),
    .busy       (erase_busy),
    .done       (erase_done)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  unknown_reply_a: assert property (
    state_r == S_EXEC && !known |=> !op_start && rsp_valid &&
      rsp_word[15:12] == RES_UNKNOWN)
    else $error("unknown command not answered with unknown code");
  cmd_echo_a: assert property (
    state_r == S_HDR0 |-> rsp_word[11:8] == op_r)
    else $error("header does not echo command code");
  short_len_a: assert property (
    state_r == S_HDR1 && op_r != OP_CODE_READ |-> rsp_word == HDR_WORDS)
    else $error("non-read response length is not two");
  version_byte_a: assert property (
    state_r == S_EXEC && op_r == OP_VER_Q && len_ok |=>
      rsp_word == {RES_PASS, OP_VER_Q, ver_major, ver_minor})
    else $error("version query answer wrong");
  verify_code_a: assert property (
    state_r == S_WAIT && op_done && !op_error && op_verify_fail &&
      (op_r == OP_ROW_PROG || op_r == OP_ID_PROG) |=>
      rsp_word == {RES_FAIL, op_r, QE_VERIFY})
    else $error("verify failure not reported as code 1");
  other_error_a: assert property (
    state_r == S_WAIT && op_done && op_error |=>
      rsp_word == {RES_FAIL, op_r, QE_OTHER})
    else $error("other error not reported as code 2");
  blank_byte_a: assert property (
    state_r == S_WAIT && op_done && !op_error && !op_verify_fail &&
      op_r == OP_BLANK_Q |=> rsp_word[15:12] == RES_PASS &&
      rsp_word[7:0] == ($past(op_blank) ? QE_BLANK : QE_NOT_BLANK))
    else $error("blank query byte wrong");
  pass_zero_a: assert property (
    state_r == S_WAIT && op_done && !op_error && !op_verify_fail &&
      op_r != OP_BLANK_Q |=> rsp_word == {RES_PASS, op_r, QE_OK})
    else $error("successful command byte not zero");
  one_cmd_a: assert property (
    state_r inside {S_EXEC, S_WAIT, S_HDR0, S_HDR1, S_DATA} |-> !cmd_ready)
    else $error("command accepted while one is in progress");
  no_early_a: assert property (
    op_start |-> !rsp_valid [*2])
    else $error("response started before processing completed");
  read_len_a: assert property (
    state_r == S_HDR1 && data_ok_r |-> rsp_word == rsp_len(n_r))
    else $error("read response length wrong");

  unknown_cmd_reply_c:  cover property (state_r == S_EXEC && !known ##1 rsp_take);
  read_c:  cover property (state_r == S_DATA && rsp_take &&
                           left_r == 16'h0001);
  fail_c:  cover property (state_r == S_WAIT && op_done && op_verify_fail);
  erase_c: cover property (erase_done);
endmodule // pe_responder

// file: rtl/pe_resp_pkg.sv
// constants for the executive command responder and erase control
// assumes a single 50 MHz clock and a synchronous active-high reset
package pe_resp_pkg;
  // response result codes
  localparam logic [3:0]  RES_PASS      = 4'h1;
  localparam logic [3:0]  RES_FAIL      = 4'h2;
  localparam logic [3:0]  RES_UNKNOWN   = 4'h3;
  // command codes
  localparam logic [3:0]  OP_CODE_READ  = 4'h2;
  localparam logic [3:0]  OP_ID_PROG    = 4'h4;
  localparam logic [3:0]  OP_ROW_PROG   = 4'h5;
  localparam logic [3:0]  OP_BLANK_Q    = 4'ha;
  localparam logic [3:0]  OP_VER_Q      = 4'hb;
  localparam logic [3:0]  OP_WORD_PROG  = 4'hd;
  // command lengths in words, header included
  localparam logic [11:0] LEN_READ      = 12'h004;
  localparam logic [11:0] LEN_ID_PROG   = 12'h004;
  localparam logic [11:0] LEN_ROW_PROG  = 12'h063;
  localparam logic [11:0] LEN_BLANK     = 12'h003;
  localparam logic [11:0] LEN_VER       = 12'h001;
  localparam logic [11:0] LEN_WORD_PROG = 12'h004;
  // query/error byte values
  localparam logic [7:0]  QE_OK         = 8'h00;
  localparam logic [7:0]  QE_VERIFY     = 8'h01;
  localparam logic [7:0]  QE_OTHER      = 8'h02;
  localparam logic [7:0]  QE_BLANK      = 8'hf0;
  localparam logic [7:0]  QE_NOT_BLANK  = 8'h0f;
  localparam logic [15:0] HDR_WORDS     = 16'h0002;
  // nonvolatile control register
  localparam int          NVM_WIP_BIT   = 15;
  localparam int          NVM_WREN_BIT  = 14;
  localparam logic [7:0]  NVM_ERASE_OP  = 8'h42;
  localparam logic [15:0] NVM_RESET     = 16'h0000;
  localparam logic [7:0]  PAGE_RESET    = 8'h00;
  localparam logic [7:0]  EXEC_PAGE     = 8'h80;
  // timing
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          ERASE_TIME_NS = 40000;
  localparam int          ERASE_CYCLES  =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // expected command length; zero marks an unknown command
  function automatic logic [11:0] exp_len(input logic [3:0] op);
    case (op)
      OP_CODE_READ: return LEN_READ;
      OP_ID_PROG:   return LEN_ID_PROG;
      OP_ROW_PROG:  return LEN_ROW_PROG;
      OP_BLANK_Q:   return LEN_BLANK;
      OP_VER_Q:     return LEN_VER;
      OP_WORD_PROG: return LEN_WORD_PROG;
      default:      return 12'h000;
    endcase
  endfunction

  // read response length: three words per packed pair plus header
  function automatic logic [15:0] rsp_len(input logic [15:0] n);
    logic [16:0] pairs;
    pairs = ({1'b0, n} + 17'h00001) >> 1;
    return 16'(pairs * 17'h00003 + 17'h00002);
  endfunction
endpackage

// file: rtl/resp_packer.sv
// packs 24-bit program words, two at a time, into three 16-bit words
// assumes in_last marks the final word; an odd one is zero-padded
`timescale 1ns/10ps
module resp_packer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [23:0] in_word,
  input  wire logic        in_last,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [15:0]      out_word
);
  import pe_resp_pkg::*;
  logic [23:0] lo_r;
  logic [23:0] hi_r;
  logic        have_r;
  logic        full_r;
  logic [1:0]  idx_r;

  assign in_ready  = !full_r;
  assign out_valid = full_r;

  always_comb begin
    case (idx_r)
      2'h0:    out_word = lo_r[15:0];
      2'h1:    out_word = {hi_r[23:16], lo_r[23:16]};
      default: out_word = hi_r[15:0];
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lo_r   <= 24'h000000;
      hi_r   <= 24'h000000;
      have_r <= 1'b0;
      full_r <= 1'b0;
      idx_r  <= 2'h0;
    end else if (in_valid && in_ready) begin
      if (!have_r) begin
        lo_r   <= in_word;
        hi_r   <= 24'h000000;
        have_r <= !in_last;
        full_r <= in_last;
      end else begin
        hi_r   <= in_word;
        have_r <= 1'b0;
        full_r <= 1'b1;
      end
      idx_r <= 2'h0;
    end else if (out_valid && out_ready) begin
      full_r <= (idx_r != 2'h2);
      idx_r  <= (idx_r == 2'h2) ? 2'h0 : idx_r + 2'h1;
    end
  end
endmodule // resp_packer

// file: rtl/nvm_erase_ctrl.sv
// nonvolatile control register, table page and executive erase timer
// assumes the programmer loads the control word before setting bit 15
`timescale 1ns/10ps
module nvm_erase_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ctl_we,
  input  wire logic [15:0] ctl_wdata,
  input  wire logic        page_we,
  input  wire logic [7:0]  page_wdata,
  input  wire logic        tbl_write,
  output logic [15:0]      ctl_q,
  output logic [7:0]       page_q,
  output logic             busy,
  output logic             done
);
  import pe_resp_pkg::*;
  logic [11:0] cnt_r;
  logic        arm_r;
  logic        start;

  // erase needs the erase opcode, write enable and a dummy table write
  assign start = ctl_we && ctl_wdata[NVM_WIP_BIT] && !busy && arm_r &&
                 ctl_q[NVM_WREN_BIT] && ctl_q[7:0] == NVM_ERASE_OP;

  always_ff @(posedge clk) begin
    if (rst) page_q <= PAGE_RESET;
    else if (page_we) page_q <= page_wdata;
  end

  always_ff @(posedge clk) begin
    if (rst) arm_r <= 1'b0;
    else if (start) arm_r <= 1'b0;
    else if (tbl_write) arm_r <= (page_q == EXEC_PAGE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy  <= 1'b0;
      cnt_r <= 12'h000;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy  <= 1'b1;
        cnt_r <= 12'(ERASE_CYCLES);
      end else if (busy) begin
        cnt_r <= cnt_r - 12'h001;
        if (cnt_r == 12'h001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // writes are ignored while erasing so the busy flag cannot be faked
  always_ff @(posedge clk) begin
    if (rst) ctl_q <= NVM_RESET;
    else if (busy && cnt_r == 12'h001) ctl_q[NVM_WIP_BIT] <= 1'b0;
    else if (ctl_we && !busy) begin
      ctl_q              <= ctl_wdata;
      ctl_q[NVM_WIP_BIT] <= start;
    end
  end

  wip_clear_a: assert property (@(posedge clk) disable iff (rst)
    busy && cnt_r == 12'h001 |=> !ctl_q[NVM_WIP_BIT] && !busy && done)
    else $error("write-in-progress bit not cleared at erase end");
endmodule // nvm_erase_ctrl

// file: tb/pe_exec_model.sv
// executor stand-in: answers op_start with op_done, feeds code words
// assumes the bench sets the cfg inputs before each command
`timescale 1ns/10ps
module pe_exec_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        op_start,
  input  wire logic [3:0]  op_code,
  input  wire logic        rd_ready,
  input  wire logic [7:0]  cfg_delay,
  input  wire logic        cfg_vf,
  input  wire logic        cfg_err,
  input  wire logic        cfg_blank,
  input  wire logic [15:0] cfg_n,
  output logic             op_done,
  output logic             op_verify_fail,
  output logic             op_error,
  output logic             op_blank,
  output logic             rd_valid,
  output logic [23:0]      rd_word
);
  import pe_resp_pkg::*;
  logic [7:0]  wait_r;
  logic        arm_r;
  logic        feed_r;
  logic [15:0] sent_r;
  logic [23:0] pat;

  // flags only hold beside op_done, so a design sampling late sees junk
  assign op_verify_fail = op_done ? cfg_vf : ~cfg_vf;
  assign op_error       = op_done ? cfg_err : ~cfg_err;
  assign op_blank       = op_done ? cfg_blank : ~cfg_blank;
  assign pat      = {8'h30 + sent_r[7:0], 16'h1000 + sent_r};
  assign rd_valid = feed_r && (sent_r < cfg_n);
  // a word not offered shows its inverse so stale data never matches
  assign rd_word  = rd_valid ? pat : ~pat;

  always_ff @(posedge clk) begin
    if (rst) begin
      arm_r   <= 1'b0;
      op_done <= 1'b0;
      wait_r  <= 8'h00;
    end else begin
      op_done <= 1'b0;
      if (op_start) begin
        arm_r  <= 1'b1;
        wait_r <= cfg_delay;
      end else if (arm_r && wait_r == 8'h00) begin
        arm_r   <= 1'b0;
        op_done <= 1'b1;
      end else if (arm_r) begin
        wait_r <= wait_r - 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || op_start) begin
      feed_r <= 1'b0;
      sent_r <= 16'h0000;
    end else begin
      if (op_done && op_code == OP_CODE_READ) feed_r <= 1'b1;
      if (rd_valid && rd_ready) sent_r <= sent_r + 16'h0001;
    end
  end
endmodule // pe_exec_model

// file: tb/prog_exec_response_and_exec_erase_bench.sv
// self-checking bench for the executive command responder
// assumes pe_exec_model stands in for the executor port
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  num_errors++; $display("Error at %0t: got %h expected %h", \
  $time, g, e); end end
module prog_exec_response_and_exec_erase_bench;
  import pe_resp_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, rsp_ready = 1'b0;
  logic        nvm_we = 1'b0, page_we = 1'b0, tbl_write = 1'b0;
  logic        ex_vf = 1'b0, ex_err = 1'b0, ex_blank = 1'b0, rdy_n;
  logic [15:0] cmd_word = 16'h0000, nvm_wdata = 16'h0000, ex_n = 16'h0000;
  logic [7:0]  page_wdata = 8'h00, ex_delay = 8'h02;
  logic [3:0]  ver_major = 4'h0, ver_minor = 4'h0;
  logic        cmd_ready, rsp_valid, op_start, op_done, op_verify_fail;
  logic        op_error, op_blank, rd_valid, rd_ready, busy;
  logic        erase_busy, erase_done;
  logic [15:0] rsp_word, nvm_ctl, e;
  logic [3:0]  op_code;
  logic [23:0] rd_word;
  logic [7:0]  table_page;
  logic        arg_valid;
  logic [15:0] arg_word;
  logic [11:0] arg_index;
  logic [15:0] arg_q[$];
  logic [3:0]  cur_op = 4'h0;
  int          arg_n = 0;
  logic [31:0] rng = 32'h41ebcb31;
  logic [15:0] exp_q[$];
  int          num_errors = 0, check_count = 0;

  pe_responder i_pe_responder (.clk, .rst, .cmd_valid, .cmd_ready,
    .cmd_word, .rsp_valid, .rsp_ready, .rsp_word, .arg_valid,
    .arg_word, .arg_index, .op_start, .op_code, .op_done,
    .op_verify_fail, .op_error, .op_blank, .ver_major, .ver_minor,
    .rd_valid, .rd_ready, .rd_word, .nvm_we, .nvm_wdata, .page_we,
    .page_wdata, .tbl_write, .nvm_ctl, .table_page, .erase_busy,
    .erase_done, .busy);
  pe_exec_model i_pe_exec_model (.clk, .rst, .op_start, .op_code,
    .rd_ready, .cfg_delay(ex_delay), .cfg_vf(ex_vf), .cfg_err(ex_err),
    .cfg_blank(ex_blank), .cfg_n(ex_n), .op_done, .op_verify_fail,
    .op_error, .op_blank, .rd_valid, .rd_word);

  initial begin
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [23:0] pat(input int k);
    return {8'h30 + 8'(k), 16'h1000 + 16'(k)};
  endfunction

  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic timeout();
    num_errors++;
    tally_and_finish();
  endtask

  // the programmer stalls about a quarter of the response words
  always @(posedge clk) begin
    rsp_ready <= (xs() & 32'h0000_0104) != 32'h0;
  end

  // values latched mid-cycle equal those seen at the next rising edge
  always @(negedge clk) begin
    rdy_n = cmd_ready;
    if (rst === 1'b0 && rsp_valid !== 1'b0 && rsp_ready === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx;
      `CHK(rsp_word, e)
    end
    if (rst === 1'b0 && arg_valid !== 1'b0) begin
      arg_n++;
      `CHK(arg_index, 12'(arg_n))
      e = arg_q.size() > 0 ? arg_q.pop_front() : 16'hxxxx;
      `CHK(arg_word, e)
    end
    if (rst === 1'b0 && op_start !== 1'b0)
      `CHK(op_code, cur_op)
  end

  task automatic put(input logic [15:0] w);
    int t;
    cmd_valid <= 1'b1;
    cmd_word  <= w;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (!rdy_n && t < 200);
    if (t >= 200) timeout();
  endtask

  task automatic run(input logic [15:0] w0, input logic [15:0] a1,
                     input logic [15:0] hdr, input int n, input bit exe);
    int nw, t;
    logic [23:0] p1, p2;
    logic [15:0] aw;
    nw = (w0[11:0] == 12'h000) ? 1 : int'(w0[11:0]);
    exp_q.push_back(hdr);
    exp_q.push_back(hdr == 16'h1200 ? 16'(3 * ((n + 1) / 2) + 2)
                                    : HDR_WORDS);
    for (int i = 0; hdr == 16'h1200 && i < n; i += 2) begin
      p1 = pat(i);
      p2 = (i + 1 < n) ? pat(i + 1) : 24'h000000;
      exp_q.push_back(p1[15:0]);
      exp_q.push_back({p2[23:16], p1[23:16]});
      exp_q.push_back(p2[15:0]);
    end
    ex_n     <= 16'(n);
    ex_delay <= 8'(2 + (xs() & 32'h1f));
    cur_op = w0[15:12];
    arg_n  = 0;
    for (int i = 0; i < nw; i++) begin
      aw = i == 0 ? w0 : (i == 1 ? a1 : 16'(xs() >> 16));
      if (i > 0) arg_q.push_back(aw);
      put(aw);
    end
    cmd_valid <= 1'b0;
    @(negedge clk);
    if (exe) begin
      `CHK(rsp_valid, 1'b0)
      `CHK(busy, 1'b1)
    end
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while ((exp_q.size() != 0 || !rdy_n) && t < 3000);
    if (t >= 3000) timeout();
    `CHK(arg_n, nw - 1)
  endtask

  initial begin
    logic [31:0] v;
    logic [3:0]  op, unk [3];
    logic [11:0] ln;
    logic [7:0]  qe;
    int          f, t, nr [5];
    unk = '{4'h0, 4'h7, 4'hf};
    nr  = '{0, 1, 2, 3, 7};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    v = xs();
    ver_major <= v[3:0];
    ver_minor <= v[7:4];
    run({OP_VER_Q, LEN_VER}, 16'h0000,
        {RES_PASS, OP_VER_Q, v[3:0], v[7:4]}, 0, 0);
    for (int b = 0; b < 2; b++) begin
      ex_blank <= b[0];
      run({OP_BLANK_Q, LEN_BLANK}, 16'h0000, {RES_PASS, OP_BLANK_Q,
          b[0] ? QE_BLANK : QE_NOT_BLANK}, 0, 1);
    end
    for (int c = 0; c < 9; c++) begin
      op = c < 3 ? OP_ROW_PROG : (c < 6 ? OP_ID_PROG : OP_WORD_PROG);
      ln = c < 3 ? LEN_ROW_PROG : (c < 6 ? LEN_ID_PROG : LEN_WORD_PROG);
      f = c % 3;
      ex_vf  <= (f == 1);
      ex_err <= (f == 2);
      qe = (f == 2 || (f == 1 && op == OP_WORD_PROG)) ? QE_OTHER :
           (f == 1 ? QE_VERIFY : QE_OK);
      run({op, ln}, 16'h0000,
          {f != 0 ? RES_FAIL : RES_PASS, op, qe}, 0, 1);
    end
    ex_vf  <= 1'b0;
    ex_err <= 1'b0;
    foreach (unk[i])
      run({unk[i], 12'h002}, 16'h0000,
          {RES_UNKNOWN, unk[i], QE_OK}, 0, 0);
    run({OP_VER_Q, 12'h002}, 16'h0000,
        {RES_FAIL, OP_VER_Q, QE_OTHER}, 0, 0);
    foreach (nr[i])
      run({OP_CODE_READ, LEN_READ}, 16'(nr[i]),
          {RES_PASS, OP_CODE_READ, QE_OK}, nr[i], 1);
    // erase first; calibration save is off-block
    nvm_we    <= 1'b1;
    nvm_wdata <= 16'h4042;
    @(posedge clk);
    nvm_we     <= 1'b0;
    page_we    <= 1'b1;
    page_wdata <= EXEC_PAGE;
    @(posedge clk);
    page_we   <= 1'b0;
    tbl_write <= 1'b1;
    @(posedge clk);
    tbl_write <= 1'b0;
    nvm_we    <= 1'b1;
    nvm_wdata <= 16'hc042;
    @(posedge clk);
    nvm_we <= 1'b0;
    @(negedge clk);
    `CHK(table_page, EXEC_PAGE)
    `CHK(erase_busy, 1'b1)
    t = 0;
    while (nvm_ctl[NVM_WIP_BIT] !== 1'b0 && t < 2100) begin
      @(negedge clk);
      t++;
    end
    `CHK(erase_done, 1'b1)
    `CHK(t > ERASE_CYCLES - 4 && t < ERASE_CYCLES + 4, 1'b1)
    `CHK(nvm_ctl, 16'h4042)
    @(negedge clk);
    `CHK(erase_busy, 1'b0)
    `CHK(erase_done, 1'b0)
    // no fresh dummy write since the last erase, so no second start
    @(posedge clk);
    nvm_we <= 1'b1;
    @(posedge clk);
    nvm_we <= 1'b0;
    @(negedge clk);
    `CHK(erase_busy, 1'b0)
    `CHK(nvm_ctl, 16'h4042)
    tally_and_finish();
  end
endmodule // prog_exec_response_and_exec_erase_bench
